// file: rtl/sdmbs_core.sv
module sdmbs_core
    import sdmbs_pkg::*;
#(
    parameter logic [2:0] BL2_CODE  = SDMBS_BL2_CODE,
    parameter logic [2:0] BL4_CODE  = SDMBS_BL4_CODE,
    parameter logic [2:0] BL8_CODE  = SDMBS_BL8_CODE,
    parameter logic [2:0] BL16_CODE = SDMBS_BL16_CODE,
    parameter logic [2:0] CL2_CODE  = SDMBS_CL2_CODE,
    parameter logic [2:0] CL3_CODE  = SDMBS_CL3_CODE,
    parameter logic [2:0] PR_FULL   = SDMBS_PR_FULL,
    parameter logic [2:0] PR_HALF   = SDMBS_PR_HALF,
    parameter logic [2:0] PR_QUART  = SDMBS_PR_QUART,
    parameter bit         HAS_BL16  = 1'b1
)(
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire sdmbs_cmd_type cmd_in,
    input  wire logic          deep_pd_enter,
    input  wire logic          self_refresh,
    input  wire logic [15:0]   status_value,
    output sdmbs_beat_type     beat_out,
    output logic               rdata_valid,
    output logic [15:0]        rdata_status,
    output logic [12:0]        mode_reg,
    output logic [12:0]        ext_reg,
    output logic [2:0]         drive_strength,
    output sdmbs_cov_type      refresh_cover,
    output logic               status_pending,
    output logic               mode_err
);

    // Burst sequencer states
    typedef enum logic [2:0] {
        SDMBS_IDLE  = 3'b001,
        SDMBS_BURST = 3'b010,
        SDMBS_WAITS = 3'b100
    } sdmbs_st_type;

    // Synchronised command bus and strap inputs
    sdmbs_cmd_type cmd_s1_r, cmd_r;
    logic          dpd_s1_r, dpd_r, sr_s1_r, sr_r;

    sdmbs_st_type  st_r;            // Sequencer state
    logic [3:0]    beat_r;          // Beat counter
    logic [3:0]    last_r;          // Last beat of the burst
    logic [8:0]    start_r;         // Start column
    logic          rd_r, stat_r;    // Read and status flags
    logic          ilv_r;           // Latched order
    logic [3:0]    mask_r;          // Latched length mask
    logic [8:0]    col_w;           // Generated column
    logic [2:0]    lat_sr_r;        // Read latency shift line
    logic [2:0]    stat_sr_r;       // Status marker shift line
    logic [15:0]   rdata_nxt;       // Next status readout

    // Decoded command strobes
    logic is_mrs, is_read, is_write, is_bst;
    assign is_mrs   = cmd_r.cmd == SDMBS_CMD_MRS;
    assign is_read  = cmd_r.cmd == SDMBS_CMD_READ;
    assign is_write = cmd_r.cmd == SDMBS_CMD_WRITE;
    assign is_bst   = cmd_r.cmd == SDMBS_CMD_BST;

    // Length mask from the programmed code
    logic [3:0] len_mask;
    always_comb begin
        unique case (mode_reg[SDMBS_BL_LSB +: 3])
            BL2_CODE:  len_mask = 4'h1;
            BL4_CODE:  len_mask = 4'h3;
            BL8_CODE:  len_mask = 4'h7;
            BL16_CODE: len_mask = HAS_BL16 ? 4'hF : 4'h7;
            default:   len_mask = 4'h7;
        endcase
    end

    // Two-stage input synchronisers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_s1_r <= '{cmd: 4'hF, ba: 2'h0, addr: 13'h0000};
            cmd_r    <= '{cmd: 4'hF, ba: 2'h0, addr: 13'h0000};
            dpd_s1_r <= 1'b0;
            dpd_r    <= 1'b0;
            sr_s1_r  <= 1'b0;
            sr_r     <= 1'b0;
        end else begin
            cmd_s1_r <= cmd_in;
            cmd_r    <= cmd_s1_r;
            dpd_s1_r <= deep_pd_enter;
            dpd_r    <= dpd_s1_r;
            sr_s1_r  <= self_refresh;
            sr_r     <= sr_s1_r;
        end
    end

    // Base mode register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_reg <= SDMBS_MODE_RST;
        end else if (dpd_r) begin
            mode_reg <= SDMBS_MODE_RST;  // Lost in deep power down
        end else if (is_mrs && cmd_r.ba == SDMBS_BA_BASE) begin
            mode_reg <= cmd_r.addr;
        end
    end

    // Extended mode register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_reg <= SDMBS_EXT_RST;
        end else if (dpd_r) begin
            ext_reg <= SDMBS_EXT_RST;
        end else if (is_mrs && cmd_r.ba == SDMBS_BA_EXT) begin
            ext_reg <= cmd_r.addr;
        end
    end

    // Drive strength and refresh coverage outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_strength <= 3'h0;
            refresh_cover  <= SDMBS_COV_FULL;
        end else begin
            drive_strength <= ext_reg[SDMBS_DS_LSB +: 3];
            if (!sr_r) begin
                refresh_cover <= SDMBS_COV_FULL;
            end else if (ext_reg[SDMBS_PARTIAL_REFRESH_REGION_LSB +: 3] == PR_HALF) begin
                refresh_cover <= SDMBS_COV_HALF;
            end else if (ext_reg[SDMBS_PARTIAL_REFRESH_REGION_LSB +: 3] == PR_QUART) begin
                refresh_cover <= SDMBS_COV_QUART;
            end else begin
                refresh_cover <= SDMBS_COV_FULL;
            end
        end
    end

    // Reserved code detection, for the user side
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_err <= 1'b0;
        end else begin
            mode_err <= (mode_reg[SDMBS_CL_LSB +: 3] != CL2_CODE
                      && mode_reg[SDMBS_CL_LSB +: 3] != CL3_CODE)
                      || (ext_reg[SDMBS_PARTIAL_REFRESH_REGION_LSB +: 3] != PR_FULL
                      && ext_reg[SDMBS_PARTIAL_REFRESH_REGION_LSB +: 3] != PR_HALF
                      && ext_reg[SDMBS_PARTIAL_REFRESH_REGION_LSB +: 3] != PR_QUART);
        end
    end

    // Status request flag, set wins over clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_pending <= 1'b0;
        end else if (is_mrs && cmd_r.ba == SDMBS_BA_STATUS
                     && cmd_r.addr == SDMBS_STAT_SEL0) begin
            status_pending <= 1'b1;
        end else if (is_read || dpd_r) begin
            status_pending <= 1'b0;
        end
    end

    // Burst sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r    <= SDMBS_IDLE;
            beat_r  <= 4'h0;
            last_r  <= 4'h0;
            start_r <= 9'h000;
            rd_r    <= 1'b0;
            stat_r  <= 1'b0;
            ilv_r   <= 1'b0;
            mask_r  <= 4'h1;
        end else if (is_read || is_write) begin
            st_r    <= SDMBS_BURST;
            beat_r  <= 4'h0;
            start_r <= cmd_r.addr[8:0];
            rd_r    <= is_read;
            stat_r  <= is_read && status_pending;
            ilv_r   <= mode_reg[SDMBS_BT_BIT];
            // Same length for reads and writes; status fixed two
            mask_r  <= (is_read && status_pending) ? 4'h1 : len_mask;
            last_r  <= (is_read && status_pending) ? 4'h1
                                                   : len_mask;
        end else begin
            unique case (st_r)
                SDMBS_IDLE: begin
                    beat_r <= 4'h0;
                end
                SDMBS_BURST: begin
                    // Terminate ends a read early
                    if (beat_r == last_r || (is_bst && rd_r)) begin
                        st_r <= SDMBS_WAITS;
                    end
                    beat_r <= 4'(beat_r + 4'h1);
                end
                SDMBS_WAITS: begin
                    st_r <= SDMBS_IDLE;
                end
                default: st_r <= SDMBS_IDLE;
            endcase
        end
    end

    // Column generator
    sdmbs_colgen sdmbs_colgen_inst (
        .start_col  (start_r),
        .beat       (beat_r),
        .len_mask   (mask_r),
        .interleave (ilv_r),
        .col        (col_w)
    );

    // Registered beat output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            beat_out <= '0;
        end else begin
            beat_out.valid     <= st_r == SDMBS_BURST;
            beat_out.is_read   <= rd_r;
            beat_out.is_status <= stat_r;
            beat_out.col       <= col_w;
        end
    end

    // Latency line: read launch delayed by CL minus one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lat_sr_r  <= 3'h0;
            stat_sr_r <= 3'h0;
        end else begin
            lat_sr_r  <= {lat_sr_r[1:0], is_read};
            stat_sr_r <= {stat_sr_r[1:0], is_read && status_pending};
        end
    end

    // First data strobe, CL2 one cycle, CL3 two cycles later
    logic lat_hit, stat_hit;
    assign lat_hit  = (mode_reg[SDMBS_CL_LSB +: 3] == CL3_CODE)
                      ? lat_sr_r[1] : lat_sr_r[0];
    assign stat_hit = (mode_reg[SDMBS_CL_LSB +: 3] == CL3_CODE)
                      ? stat_sr_r[1] : stat_sr_r[0];
    assign rdata_nxt = stat_hit ? status_value : 16'h0000;

    // Read data marker and status contents
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_valid  <= 1'b0;
            rdata_status <= 16'h0000;
        end else begin
            rdata_valid  <= lat_hit;
            rdata_status <= rdata_nxt;
        end
    end

    // Assertions
    sequence s_status_req;
        is_mrs && cmd_r.ba == SDMBS_BA_STATUS
            && cmd_r.addr == SDMBS_STAT_SEL0;
    endsequence

    sequence s_read_cmd;
        is_read;
    endsequence

    a_base_write: assert property (@(posedge clk) disable iff (reset)
        is_mrs && cmd_r.ba == SDMBS_BA_BASE && !dpd_r
        |=> mode_reg == $past(cmd_r.addr))
        else $error("base register not written");

    a_base_hold: assert property (@(posedge clk) disable iff (reset)
        !is_mrs && !dpd_r |=> $stable(mode_reg))
        else $error("base register changed");

    a_ext_write: assert property (@(posedge clk) disable iff (reset)
        is_mrs && cmd_r.ba == SDMBS_BA_EXT && !dpd_r
        |=> ext_reg == $past(cmd_r.addr))
        else $error("extended register not written");

    a_status_set: assert property (@(posedge clk) disable iff (reset)
        s_status_req |=> status_pending)
        else $error("status request lost");

    a_status_len: assert property (@(posedge clk) disable iff (reset)
        s_read_cmd and status_pending |=> last_r == 4'h1)
        else $error("status burst not two");

    a_lat_cl2: assert property (@(posedge clk) disable iff (reset)
        s_read_cmd and mode_reg[SDMBS_CL_LSB +: 3] == CL2_CODE
        |=> ##1 rdata_valid)
        else $error("latency two missed");

    a_lat_cl3: assert property (@(posedge clk) disable iff (reset)
        s_read_cmd and mode_reg[SDMBS_CL_LSB +: 3] == CL3_CODE
        |=> !rdata_valid ##1 !rdata_valid ##1 rdata_valid)
        else $error("latency three missed");

    a_wrap_block: assert property (@(posedge clk) disable iff (reset)
        st_r == SDMBS_BURST |-> (col_w & ~{5'h00, mask_r})
            == (start_r & ~{5'h00, mask_r}))
        else $error("burst left block");

    a_partial_refresh_region_only: assert property (@(posedge clk) disable iff (reset)
        !sr_r |=> refresh_cover == SDMBS_COV_FULL)
        else $error("region outside self refresh");

    a_same_len: assert property (@(posedge clk) disable iff (reset)
        is_write && !status_pending |=> last_r == $past(len_mask))
        else $error("write length differs");

endmodule : sdmbs_core

// file: rtl/sdmbs_pkg.sv
package sdmbs_pkg;

    // Bank-select codes for a mode-register-set command
    localparam logic [1:0] SDMBS_BA_BASE   = 2'h0;
    localparam logic [1:0] SDMBS_BA_STATUS = 2'h1;
    localparam logic [1:0] SDMBS_BA_EXT    = 2'h2;

    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] SDMBS_CMD_MRS   = 4'h0;
    localparam logic [3:0] SDMBS_CMD_READ  = 4'h5;
    localparam logic [3:0] SDMBS_CMD_WRITE = 4'h4;
    localparam logic [3:0] SDMBS_CMD_BST   = 4'h6;

    // Base mode register field positions
    localparam int SDMBS_BL_LSB   = 0;
    localparam int SDMBS_BT_BIT   = 3;
    localparam int SDMBS_CL_LSB   = 4;
    // Extended mode register field positions
    localparam int SDMBS_PARTIAL_REFRESH_REGION_LSB = 0;
    localparam int SDMBS_DS_LSB   = 5;

    // Field codes
    localparam logic [2:0] SDMBS_BL2_CODE  = 3'h1;
    localparam logic [2:0] SDMBS_BL4_CODE  = 3'h2;
    localparam logic [2:0] SDMBS_BL8_CODE  = 3'h3;
    localparam logic [2:0] SDMBS_BL16_CODE = 3'h4;
    localparam logic [2:0] SDMBS_CL2_CODE  = 3'h2;
    localparam logic [2:0] SDMBS_CL3_CODE  = 3'h3;
    localparam logic [2:0] SDMBS_PR_FULL   = 3'h0;
    localparam logic [2:0] SDMBS_PR_HALF   = 3'h1;
    localparam logic [2:0] SDMBS_PR_QUART  = 3'h2;

    // Reset values of the stored registers
    localparam logic [12:0] SDMBS_MODE_RST = 13'h0032;
    localparam logic [12:0] SDMBS_EXT_RST  = 13'h0000;

    // Status register selector defined for readout
    localparam logic [12:0] SDMBS_STAT_SEL0 = 13'h0000;

    // Region coverage codes
    typedef enum logic [1:0] {
        SDMBS_COV_FULL  = 2'h0,
        SDMBS_COV_HALF  = 2'h1,
        SDMBS_COV_QUART = 2'h2
    } sdmbs_cov_type;

    // One sampled command
    typedef struct packed {
        logic [3:0]  cmd;
        logic [1:0]  ba;
        logic [12:0] addr;
    } sdmbs_cmd_type;

    // One beat on the column sequencer output
    typedef struct packed {
        logic       valid;
        logic       is_read;
        logic       is_status;
        logic [8:0] col;
    } sdmbs_beat_type;

endpackage : sdmbs_pkg

// file: rtl/sdmbs_colgen.sv
// Offset k of a burst inside the aligned block
module sdmbs_colgen
    import sdmbs_pkg::*;
(
    input  wire logic [8:0] start_col,
    input  wire logic [3:0] beat,
    input  wire logic [3:0] len_mask,
    input  wire logic       interleave,
    output logic [8:0]      col
);
    logic [3:0] offs; // Offset inside the block
    always_comb begin
        // Interleave xors, sequential adds; mask wraps in the block
        if (interleave) begin
            offs = (start_col[3:0] ^ beat) & len_mask;
        end else begin
            offs = 4'(start_col[3:0] + beat) & len_mask;
        end
        // Upper bits keep the aligned block
        col = (start_col & ~{5'h00, len_mask}) | {5'h00, offs};
    end
endmodule : sdmbs_colgen

// file: test/sdmbs_ctrl_model.sv
// Memory controller side: drives the command bus one command at a time
module sdmbs_ctrl_model
    import sdmbs_pkg::*;
#(
    parameter int MODE_WAIT = 4, // Idle edges after a mode set
    parameter int SR_GAP    = 4  // Idle edges from status request to read
)(
    input  wire logic     clk,
    output sdmbs_cmd_type cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus starts deselected
    initial cmd_out = '{cmd: 4'hF, ba: 2'h3, addr: 13'h1FFF};

    // One command edge, then deselect with inverted stale lines
    task automatic send(input logic [3:0] c, input logic [1:0] b,
                        input logic [12:0] a, input int idle);
        cmd_out = '{cmd: c, ba: b, addr: a};
        @(posedge clk);
        #2;
        cmd_out = '{cmd: 4'hF, ba: ~b, addr: ~a};
        repeat (idle) begin
            @(posedge clk);
            #2;
        end
    endtask : send

    // Mode set with undefined bits zeroed, then settle gap
    task automatic mode_write(input logic [1:0] b, input logic [12:0] a);
        logic [12:0] m;
        m = (b == SDMBS_BA_EXT) ? (a & 13'h00E7) : (a & 13'h007F);
        send(SDMBS_CMD_MRS, b, m, MODE_WAIT);
    endtask : mode_write

    // Status request on idle banks, only deselects until the read
    task automatic status_req(input logic [12:0] a);
        send(SDMBS_CMD_MRS, SDMBS_BA_STATUS, a, SR_GAP);
    endtask : status_req

    // Column access, recovery kept before the next command
    task automatic access(input logic wr, input logic [8:0] col,
                          input int idle);
        send(wr ? SDMBS_CMD_WRITE : SDMBS_CMD_READ, 2'h0,
             {4'h0, col}, idle);
    endtask : access
endmodule : sdmbs_ctrl_model

// file: test/sdmbs_core_tb.sv
// Self-checking bench for the mode, burst and status block
module sdmbs_core_tb
    import sdmbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk           = 1'b0;
    logic           reset         = 1'b1;
    logic           deep_pd_enter = 1'b0;
    logic           self_refresh  = 1'b0;
    logic [15:0]    status_value  = 16'h0000;
    sdmbs_cmd_type  cmd_in;
    sdmbs_beat_type beat_out;
    logic           rdata_valid;
    logic [15:0]    rdata_status;
    logic [12:0]    mode_reg;
    logic [12:0]    ext_reg;
    logic [2:0]     drive_strength;
    sdmbs_cov_type  refresh_cover;
    logic           status_pending;
    logic           mode_err;
    int             failures = 0;     // Mismatch count
    int             checked  = 0;     // Comparison count
    int             cyc      = 0;     // Edge counter
    integer         seed     = 32'h30c6;
    logic [11:0]    exp_beats[$];     // Expected beats in order
    logic [47:0]    exp_rd[$];        // Expected {edge, status}

    sdmbs_core sdmbs_core_inst (.clk(clk), .reset(reset), .cmd_in(cmd_in),
        .deep_pd_enter(deep_pd_enter), .self_refresh(self_refresh),
        .status_value(status_value), .beat_out(beat_out),
        .rdata_valid(rdata_valid), .rdata_status(rdata_status),
        .mode_reg(mode_reg), .ext_reg(ext_reg),
        .drive_strength(drive_strength), .refresh_cover(refresh_cover),
        .status_pending(status_pending), .mode_err(mode_err));
    sdmbs_ctrl_model sdmbs_ctrl_model_inst (.clk(clk), .cmd_out(cmd_in));

    // Clock and edge count
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // Compare and count
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Step n edges, landing just after the edge
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask : tick

    // Note expected beats and first data, then issue the access
    task automatic burst(input logic wr, input logic [8:0] st, input int bl,
                         input logic il, input int cl, input logic sr);
        logic [8:0] m;
        logic [8:0] o;
        m = 9'(bl - 1);
        for (int k = 0; k < bl; k++) begin
            o = il ? (st ^ 9'(k)) : (st + 9'(k));
            exp_beats.push_back({1'b1, ~wr, sr, (st & ~m) | (o & m)});
        end
        if (!wr) begin
            // Command edge, two sync edges, then latency minus one
            exp_rd.push_back({32'(cyc + 2 + cl), sr ? status_value : 16'h0});
        end
        sdmbs_ctrl_model_inst.access(wr, st, bl + cl + 6);
    endtask : burst

    // Output watcher: takes the oldest note per result
    always @(posedge clk) begin
        logic [47:0] t;
        #1;
        if (beat_out.valid === 1'b1) begin
            if (exp_beats.size() == 0) begin
                check("extra beat", 32'h0, 32'(beat_out));
            end else begin
                check("beat", exp_beats.pop_front(), beat_out);
            end
        end
        if (rdata_valid === 1'b1) begin
            if (exp_rd.size() == 0) begin
                check("extra rdata", 32'h0, 32'h1);
            end else begin
                t = exp_rd.pop_front();
                check("rdata edge", t[47:16], cyc);
                check("rdata status", t[15:0], rdata_status);
            end
        end
    end

    // Main sequence
    initial begin
        logic [2:0]  blc [4];
        logic [2:0]  prc [3];
        logic [2:0]  d;
        logic [12:0] a;
        logic [8:0]  c;
        int          bl;
        int          cl;
        blc = '{SDMBS_BL2_CODE, SDMBS_BL4_CODE, SDMBS_BL8_CODE,
                SDMBS_BL16_CODE};
        prc = '{SDMBS_PR_FULL, SDMBS_PR_HALF, SDMBS_PR_QUART};
        status_value = 16'($random(seed));
        repeat (6) @(posedge clk);
        #2;
        reset = 1'b0;
        tick(1);
        check("mode reset", SDMBS_MODE_RST, mode_reg);
        check("ext reset", SDMBS_EXT_RST, ext_reg);
        check("cover reset", SDMBS_COV_FULL, refresh_cover);
        // Every length, order and latency, read then write
        for (int i = 0; i < 16; i++) begin
            bl = 2 << i[1:0];
            cl = i[3] ? 3 : 2;
            a = {6'h0, i[3] ? SDMBS_CL3_CODE : SDMBS_CL2_CODE, i[2],
                 blc[i[1:0]]};
            sdmbs_ctrl_model_inst.mode_write(SDMBS_BA_BASE, a);
            check("mode reg", a, mode_reg);
            burst(1'b0, 9'($random(seed)), bl, i[2], cl, 1'b0);
            burst(1'b1, 9'($random(seed)), bl, i[2], cl, 1'b0);
        end
        // Extended register: regions and drive, refresh only
        for (int r = 0; r < 3; r++) begin
            d = 3'($random(seed));
            a = {5'h0, d, 2'h0, prc[r]};
            sdmbs_ctrl_model_inst.mode_write(SDMBS_BA_EXT, a);
            check("ext reg", a, ext_reg);
            check("drive", d, drive_strength);
            check("mode kept", {6'h0, SDMBS_CL3_CODE, 1'b1,
                  SDMBS_BL16_CODE}, mode_reg);
            check("mode ok", 1'b0, mode_err);
            check("cover awake", SDMBS_COV_FULL, refresh_cover);
            self_refresh = 1'b1;
            tick(5);
            check("cover", r, refresh_cover);
            self_refresh = 1'b0;
            tick(5);
        end
        // Status readout with length eight programmed
        a = {6'h0, SDMBS_CL2_CODE, 1'b0, SDMBS_BL8_CODE};
        sdmbs_ctrl_model_inst.mode_write(SDMBS_BA_BASE, a);
        sdmbs_ctrl_model_inst.status_req(SDMBS_STAT_SEL0);
        check("pending", 1'b1, status_pending);
        burst(1'b0, 9'($random(seed)), 2, 1'b0, 2, 1'b1);
        check("pending clear", 1'b0, status_pending);
        // Undefined selector is ignored, next read is ordinary
        sdmbs_ctrl_model_inst.status_req(13'h0001);
        check("refused", 1'b0, status_pending);
        burst(1'b0, 9'($random(seed)), 8, 1'b0, 2, 1'b0);
        // Terminate three edges after a read leaves three beats
        c = 9'($random(seed));
        for (int k = 0; k < 3; k++) begin
            exp_beats.push_back({3'b110, c[8:3], 3'(c[2:0] + k)});
        end
        exp_rd.push_back({32'(cyc + 4), 16'h0000});
        sdmbs_ctrl_model_inst.access(1'b0, c, 2);
        sdmbs_ctrl_model_inst.send(SDMBS_CMD_BST, 2'h0, 13'h0000, 12);
        // Reserved latency code flagged
        sdmbs_ctrl_model_inst.mode_write(SDMBS_BA_BASE, {a[12:7], 3'h1, a[3:0]});
        check("mode err", 1'b1, mode_err);
        // Deep power down returns both registers to their reset values
        deep_pd_enter = 1'b1;
        tick(5);
        check("mode pd", SDMBS_MODE_RST, mode_reg);
        check("ext pd", SDMBS_EXT_RST, ext_reg);
        deep_pd_enter = 1'b0;
        tick(4);
        for (int w = 0; w < 50 && exp_beats.size() + exp_rd.size() > 0; w++)
            tick(1);
        check("left", 32'h0, 32'(exp_beats.size() + exp_rd.size()));
        complete_run();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        check("timeout", 32'h0, 32'h1);
        complete_run();
    end
endmodule : sdmbs_core_tb
